// ==== pkg/safe_pv_defines.svh ====
// Object indices, sub-indices, field positions and reset values of the safe process value objects.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef SAFE_PV_DEFINES_SVH
`define SAFE_PV_DEFINES_SVH

// Object indices
`define IDX_INV_STATUS 16'h4000
`define IDX_INV_TILT_LONG 16'h4010
`define IDX_INV_TILT_LAT 16'h4020
`define IDX_INV_ACCEL 16'h4130
`define IDX_INV_RATE 16'h4131
`define IDX_STATUS 16'h5000
`define IDX_ACCEL 16'h5130
`define IDX_RATE 16'h5131
`define IDX_TILT_LONG 16'h6010
`define IDX_TILT_LAT 16'h6020
`define IDX_TILT_LAT_CFG 16'h6021

// Sub-indices
`define SUB_MAIN 8'h00
`define SUB_AXIS_X 8'h01
`define SUB_AXIS_Z 8'h03

// Array size reported at sub-index 0
`define AXIS_COUNT 8'h03

// Lateral configuration fields
`define CFG_NEGATE_BIT 0
`define CFG_SCALE_BIT 1
`define CFG_RESET 8'h00

// Reset values of the plain values, frame number, frames and received data
`define PLAIN_RESET 16'h0000
`define STATUS_RESET 8'h00
`define NUM_RESET 2'h0
`define FRAME_RESET 48'h000000000000
`define RX_RESET 64'h0000000000000000

// Padding byte of the first safety frame
`define FRAME_PAD 8'h00

`endif

// ==== pkg/safe_pv_pkg.sv ====
// Types shared by the safe process value objects.
// Assumes the defines header is compiled alongside.
package safe_pv_pkg;

    // Transmit sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_TPDO = 5'b00010,
        ST_SRDO1 = 5'b00100,
        ST_SRDO2 = 5'b01000,
        ST_SRDO3 = 5'b10000
    } tx_state_t;

    // Number of a safety data object on the link
    typedef logic [1:0] srdo_num_t;

endpackage

// ==== hdl/value_pair.sv ====
// One process value held twice: plain and bitwise complement.
// Assumes load comes from logic on the same clock.
`timescale 1ns/1ns
`include "safe_pv_defines.svh"

module value_pair #(
    parameter int WIDTH = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] plain_r,
    output logic [WIDTH-1:0] inv_r
);

    logic [WIDTH-1:0] plain_nxt;
    logic [WIDTH-1:0] inv_nxt;

    // Both copies take the new value in the same cycle
    always_comb begin
        plain_nxt = plain_r;
        inv_nxt = inv_r;
        if (load) begin
            plain_nxt = d; // RL1
            inv_nxt = ~d; // RL2
        end
    end

    // Reset keeps the pair complementary as well
    always_ff @(posedge clk) begin
        if (reset) begin
            plain_r <= WIDTH'(`PLAIN_RESET);
            inv_r <= ~WIDTH'(`PLAIN_RESET); // RL2
        end else begin
            plain_r <= plain_nxt;
            inv_r <= inv_nxt;
        end
    end

endmodule // value_pair

// ==== hdl/safety_frame_check.sv ====
// Consistency check of a safety frame: inverted half must be the complement of the plain half.
// Assumes both halves come from registers on the same clock.
`timescale 1ns/1ns

module safety_frame_check #(
    parameter int WIDTH = 48
) (
    input wire logic [WIDTH-1:0] plain,
    input wire logic [WIDTH-1:0] inverse,
    output logic consistent
);

    // Every bit must differ between the halves
    assign consistent = (plain == ~inverse); // RL3

endmodule // safety_frame_check

// ==== hdl/safe_process_value_objects.sv ====
// Safe process value objects of a safety inclinometer: plain and inverted copies,
// object read/write port, one transmit and one receive process data channel, safety frames.
// Assumes sensor samples and object requests come from logic on clk.
`timescale 1ns/1ns
`include "safe_pv_defines.svh"

// Notes on behaviour
// RL1: Each safety signal exists as a plain object and a separate companion object.
// RL2: Companion always equals the bitwise complement, loaded in the same cycle.
// RL3: Safety frames carry plain and inverted copies together; mismatches are never sent.
// RL4: Plain status and tilt values go out in the transmit process data object on each sample taken.
// RL5: The lateral configuration object changes how the lateral value is represented.
// RL6: Two safety frames without the rate sensor, three when it is fitted.
// RL7: Exactly one received process data object is accepted and held.
// RL8: Configuration bit 0 negates lateral tilt; bit 1 scaling is ignored.
module safe_process_value_objects #(
    parameter bit RATE_FITTED = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic [7:0] sample_status,
    input wire logic [15:0] sample_tilt_long,
    input wire logic [15:0] sample_tilt_lat,
    input wire logic [15:0] sample_accel_x,
    input wire logic [15:0] sample_accel_y,
    input wire logic [15:0] sample_accel_z,
    input wire logic [15:0] sample_rate_x,
    input wire logic [15:0] sample_rate_y,
    input wire logic [15:0] sample_rate_z,
    input wire logic obj_req,
    input wire logic obj_write,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [15:0] obj_wdata,
    output logic obj_done_r,
    output logic obj_abort_r,
    output logic [15:0] obj_rdata_r,
    output logic tpdo_valid_r,
    output logic [7:0] tpdo_status_r,
    output logic [15:0] tpdo_tilt_long_r,
    output logic [15:0] tpdo_tilt_lat_r,
    output logic srdo_valid_r,
    output safe_pv_pkg::srdo_num_t srdo_num_r,
    output logic [47:0] srdo_plain_r,
    output logic [47:0] srdo_inverse_r,
    output logic srdo_fault_r,
    input wire logic rpdo_valid,
    input wire logic [63:0] rpdo_data,
    output logic rx_new_r,
    output logic [63:0] rx_data_r
);

    safe_pv_pkg::tx_state_t st_r;
    safe_pv_pkg::tx_state_t st_nxt;
    logic [7:0] cfg_r;
    logic [7:0] cfg_nxt;
    logic load;
    logic [15:0] lat_reported;
    logic [7:0] status_p;
    logic [7:0] status_i;
    logic [15:0] long_p;
    logic [15:0] long_i;
    logic [15:0] lat_p;
    logic [15:0] lat_i;
    logic [15:0] axis_in [6];
    logic [15:0] axis_p [6];
    logic [15:0] axis_i [6];
    logic [47:0] frame_p;
    logic [47:0] frame_i;
    logic frame_ok;

    // Samples are taken only between transmit sequences so a frame never mixes two samples
    assign load = sample_valid && (st_r == safe_pv_pkg::ST_IDLE);

    // Lateral value as represented; scaling request is not acted on
    assign lat_reported = cfg_r[`CFG_NEGATE_BIT] ? 16'(~sample_tilt_lat + 16'h0001)
                                                 : sample_tilt_lat; // RL8

    // Plain and inverted copies of each safety signal
    value_pair #(.WIDTH(8)) u_status (
        .clk(clk), .reset(reset), .load(load), .d(sample_status),
        .plain_r(status_p), .inv_r(status_i)
    ); // RL1
    value_pair #(.WIDTH(16)) u_long (
        .clk(clk), .reset(reset), .load(load), .d(sample_tilt_long),
        .plain_r(long_p), .inv_r(long_i)
    ); // RL1
    value_pair #(.WIDTH(16)) u_lat (
        .clk(clk), .reset(reset), .load(load), .d(lat_reported),
        .plain_r(lat_p), .inv_r(lat_i)
    ); // RL5

    // Acceleration axes 0..2, rate axes 3..5
    assign axis_in[0] = sample_accel_x;
    assign axis_in[1] = sample_accel_y;
    assign axis_in[2] = sample_accel_z;
    assign axis_in[3] = sample_rate_x;
    assign axis_in[4] = sample_rate_y;
    assign axis_in[5] = sample_rate_z;

    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_axis
            value_pair #(.WIDTH(16)) u_axis (
                .clk(clk), .reset(reset), .load(load), .d(axis_in[g]),
                .plain_r(axis_p[g]), .inv_r(axis_i[g])
            ); // RL1
        end
    endgenerate

    // Safety frame contents for the frame about to be sent
    always_comb begin
        frame_p = {lat_p, long_p, `FRAME_PAD, status_p};
        frame_i = {lat_i, long_i, ~`FRAME_PAD, status_i};
        unique case (st_r)
            safe_pv_pkg::ST_SRDO2: begin
                frame_p = {axis_p[2], axis_p[1], axis_p[0]};
                frame_i = {axis_i[2], axis_i[1], axis_i[0]};
            end
            safe_pv_pkg::ST_SRDO3: begin
                frame_p = {axis_p[5], axis_p[4], axis_p[3]};
                frame_i = {axis_i[5], axis_i[4], axis_i[3]};
            end
            safe_pv_pkg::ST_IDLE, safe_pv_pkg::ST_TPDO, safe_pv_pkg::ST_SRDO1: begin
                frame_p = {lat_p, long_p, `FRAME_PAD, status_p};
                frame_i = {lat_i, long_i, ~`FRAME_PAD, status_i};
            end
        endcase
    end

    safety_frame_check #(.WIDTH(48)) u_check (
        .plain(frame_p),
        .inverse(frame_i),
        .consistent(frame_ok)
    );

    // Transmit sequencer: process data, then each safety frame in turn
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            safe_pv_pkg::ST_IDLE: begin
                if (load) begin
                    st_nxt = safe_pv_pkg::ST_TPDO;
                end
            end
            safe_pv_pkg::ST_TPDO: begin
                st_nxt = safe_pv_pkg::ST_SRDO1;
            end
            safe_pv_pkg::ST_SRDO1: begin
                st_nxt = safe_pv_pkg::ST_SRDO2;
            end
            safe_pv_pkg::ST_SRDO2: begin
                st_nxt = RATE_FITTED ? safe_pv_pkg::ST_SRDO3 : safe_pv_pkg::ST_IDLE; // RL6
            end
            safe_pv_pkg::ST_SRDO3: begin
                st_nxt = safe_pv_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r <= safe_pv_pkg::ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Process data and safety frame outputs
    logic is_srdo;
    assign is_srdo = (st_r == safe_pv_pkg::ST_SRDO1) || (st_r == safe_pv_pkg::ST_SRDO2)
                     || (st_r == safe_pv_pkg::ST_SRDO3);

    logic tpdo_valid_nxt;
    logic [7:0] tpdo_status_nxt;
    logic [15:0] tpdo_tilt_long_nxt;
    logic [15:0] tpdo_tilt_lat_nxt;
    logic srdo_valid_nxt;
    safe_pv_pkg::srdo_num_t srdo_num_nxt;
    logic [47:0] srdo_plain_nxt;
    logic [47:0] srdo_inverse_nxt;
    logic srdo_fault_nxt;

    // Next values: data held between pulses, a bad frame is withheld and flagged
    always_comb begin
        tpdo_valid_nxt = (st_r == safe_pv_pkg::ST_TPDO); // RL4
        tpdo_status_nxt = tpdo_status_r;
        tpdo_tilt_long_nxt = tpdo_tilt_long_r;
        tpdo_tilt_lat_nxt = tpdo_tilt_lat_r;
        srdo_valid_nxt = is_srdo && frame_ok; // RL3
        srdo_num_nxt = srdo_num_r;
        srdo_plain_nxt = srdo_plain_r;
        srdo_inverse_nxt = srdo_inverse_r;
        srdo_fault_nxt = srdo_fault_r;
        if (st_r == safe_pv_pkg::ST_TPDO) begin
            tpdo_status_nxt = status_p; // RL4
            tpdo_tilt_long_nxt = long_p;
            tpdo_tilt_lat_nxt = lat_p;
        end
        if (is_srdo && frame_ok) begin
            srdo_plain_nxt = frame_p; // RL3
            srdo_inverse_nxt = frame_i;
            srdo_num_nxt = (st_r == safe_pv_pkg::ST_SRDO1) ? 2'h0 :
                           (st_r == safe_pv_pkg::ST_SRDO2) ? 2'h1 : 2'h2;
        end
        if (is_srdo && !frame_ok) begin
            srdo_fault_nxt = 1'b1; // RL3
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            tpdo_valid_r <= 1'b0;
            tpdo_status_r <= `STATUS_RESET;
            tpdo_tilt_long_r <= `PLAIN_RESET;
            tpdo_tilt_lat_r <= `PLAIN_RESET;
            srdo_valid_r <= 1'b0;
            srdo_num_r <= `NUM_RESET;
            srdo_plain_r <= `FRAME_RESET;
            srdo_inverse_r <= ~`FRAME_RESET;
            srdo_fault_r <= 1'b0;
        end else begin
            tpdo_valid_r <= tpdo_valid_nxt;
            tpdo_status_r <= tpdo_status_nxt;
            tpdo_tilt_long_r <= tpdo_tilt_long_nxt;
            tpdo_tilt_lat_r <= tpdo_tilt_lat_nxt;
            srdo_valid_r <= srdo_valid_nxt;
            srdo_num_r <= srdo_num_nxt;
            srdo_plain_r <= srdo_plain_nxt;
            srdo_inverse_r <= srdo_inverse_nxt;
            srdo_fault_r <= srdo_fault_nxt;
        end
    end

    // Single receive channel: latest frame held
    logic rx_new_nxt;
    logic [63:0] rx_data_nxt;

    always_comb begin
        rx_new_nxt = rpdo_valid; // RL7
        rx_data_nxt = rx_data_r;
        if (rpdo_valid) begin
            rx_data_nxt = rpdo_data; // RL7
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rx_new_r <= 1'b0;
            rx_data_r <= `RX_RESET;
        end else begin
            rx_new_r <= rx_new_nxt;
            rx_data_r <= rx_data_nxt;
        end
    end

    // Object access: decode index and sub-index
    logic [15:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic is_rate;
    logic axis_sub;
    logic [2:0] ax_sel;

    assign is_rate = (obj_index == `IDX_INV_RATE) || (obj_index == `IDX_RATE);
    assign axis_sub = (obj_sub >= `SUB_AXIS_X) && (obj_sub <= `SUB_AXIS_Z);
    assign ax_sel = 3'(obj_sub[1:0] - 2'h1) + (is_rate ? 3'h3 : 3'h0);
    assign wr_hit = (obj_index == `IDX_TILT_LAT_CFG) && (obj_sub == `SUB_MAIN);

    always_comb begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
        if (obj_sub == `SUB_MAIN) begin
            rd_hit = 1'b1;
            unique case (obj_index)
                `IDX_INV_STATUS: rd_val = {8'h00, status_i};
                `IDX_STATUS: rd_val = {8'h00, status_p};
                `IDX_INV_TILT_LONG: rd_val = long_i;
                `IDX_TILT_LONG: rd_val = long_p;
                `IDX_INV_TILT_LAT: rd_val = lat_i;
                `IDX_TILT_LAT: rd_val = lat_p;
                `IDX_TILT_LAT_CFG: rd_val = {8'h00, cfg_r};
                `IDX_INV_ACCEL, `IDX_ACCEL: rd_val = {8'h00, `AXIS_COUNT};
                `IDX_INV_RATE, `IDX_RATE: begin
                    rd_val = {8'h00, `AXIS_COUNT};
                    rd_hit = RATE_FITTED;
                end
                default: rd_hit = 1'b0;
            endcase
        end else if (axis_sub && (obj_index == `IDX_INV_ACCEL || obj_index == `IDX_INV_RATE)) begin
            rd_val = axis_i[ax_sel];
            rd_hit = !is_rate || RATE_FITTED;
        end else if (axis_sub && (obj_index == `IDX_ACCEL || obj_index == `IDX_RATE)) begin
            rd_val = axis_p[ax_sel];
            rd_hit = !is_rate || RATE_FITTED;
        end
    end

    logic obj_hit;
    logic obj_done_nxt;
    logic obj_abort_nxt;
    logic [15:0] obj_rdata_nxt;

    // Configuration write; every request answered once, one cycle later
    always_comb begin
        cfg_nxt = cfg_r;
        obj_hit = obj_write ? wr_hit : rd_hit;
        obj_done_nxt = obj_req && obj_hit;
        obj_abort_nxt = obj_req && !obj_hit;
        obj_rdata_nxt = obj_rdata_r;
        if (obj_req && obj_write && wr_hit) begin
            cfg_nxt = obj_wdata[7:0]; // RL5
        end
        if (obj_req && !obj_write && rd_hit) begin
            obj_rdata_nxt = rd_val;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= `CFG_RESET;
            obj_done_r <= 1'b0;
            obj_abort_r <= 1'b0;
            obj_rdata_r <= `PLAIN_RESET;
        end else begin
            cfg_r <= cfg_nxt;
            obj_done_r <= obj_done_nxt;
            obj_abort_r <= obj_abort_nxt;
            obj_rdata_r <= obj_rdata_nxt;
        end
    end

endmodule // safe_process_value_objects

// ==== testbench/spvo_checker.sv ====
// Port assertions for the safe process value objects.
// Assumes a bind onto the top module; one clock, sync reset.
`timescale 1ns/1ns
module spvo_checker #(
    parameter bit RATE_FITTED = 1'h1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic obj_req,
    input wire logic obj_write,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic obj_done_r,
    input wire logic obj_abort_r,
    input wire logic tpdo_valid_r,
    input wire logic [7:0] tpdo_status_r,
    input wire logic [15:0] tpdo_tilt_long_r,
    input wire logic [15:0] tpdo_tilt_lat_r,
    input wire logic srdo_valid_r,
    input wire safe_pv_pkg::srdo_num_t srdo_num_r,
    input wire logic [47:0] srdo_plain_r,
    input wire logic [47:0] srdo_inverse_r,
    input wire logic rpdo_valid,
    input wire logic [63:0] rpdo_data,
    input wire logic rx_new_r,
    input wire logic [63:0] rx_data_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // First two safety frames, one per cycle
    sequence s_frames01;
        srdo_valid_r && srdo_num_r == 2'h0 ##1 srdo_valid_r && srdo_num_r == 2'h1;
    endsequence
    a_tpdo_cause: assert property (tpdo_valid_r |-> $past(sample_valid, 2))
        else $error("tpdo without sample");
    a_frames_follow: assert property (tpdo_valid_r |=> s_frames01)
        else $error("frames 0 and 1 missing");
    a_rate_frame: assert property (tpdo_valid_r |-> ##3 (RATE_FITTED ?
        (srdo_valid_r && srdo_num_r == 2'h2) : !srdo_valid_r))
        else $error("third frame wrong");
    a_frame_inverse: assert property (srdo_valid_r |-> srdo_inverse_r == ~srdo_plain_r)
        else $error("frame halves disagree");
    a_frame_zero: assert property (srdo_valid_r && srdo_num_r == 2'h0 |->
        srdo_plain_r == {tpdo_tilt_lat_r, tpdo_tilt_long_r, 8'h00, tpdo_status_r})
        else $error("frame 0 layout");
    a_obj_answer: assert property (obj_req |=> obj_done_r != obj_abort_r)
        else $error("no single answer");
    a_write_guard: assert property (obj_req && obj_write &&
        (obj_index != 16'h6021 || obj_sub != 8'h00) |=> obj_abort_r)
        else $error("write not refused");
    a_rx_capture: assert property (rpdo_valid |=> rx_new_r && rx_data_r == $past(rpdo_data))
        else $error("receive not captured");
    a_rx_quiet: assert property (!rpdo_valid |=> !rx_new_r)
        else $error("spurious receive");
endmodule // spvo_checker
bind safe_process_value_objects spvo_checker #(.RATE_FITTED(RATE_FITTED)) spvo_checker_i (
    .clk, .reset, .sample_valid, .obj_req, .obj_write, .obj_index, .obj_sub, .obj_done_r,
    .obj_abort_r, .tpdo_valid_r, .tpdo_status_r, .tpdo_tilt_long_r, .tpdo_tilt_lat_r,
    .srdo_valid_r, .srdo_num_r, .srdo_plain_r, .srdo_inverse_r, .rpdo_valid, .rpdo_data,
    .rx_new_r, .rx_data_r);

// ==== testbench/net_master_model.sv ====
// Network master model: sends receive data, accepts safety frames.
// Assumes device frame outputs on the same clock.
`timescale 1ns/1ns
module net_master_model (
    input wire logic clk,
    input wire logic srdo_valid,
    input wire logic [47:0] srdo_plain,
    input wire logic [47:0] srdo_inverse,
    output logic rpdo_valid,
    output logic [63:0] rpdo_data
);
    int accepted = 0;
    initial rpdo_valid = 1'h0;
    initial rpdo_data = '1;
    // A frame counts only when both halves agree
    always @(posedge clk)
        if (srdo_valid && srdo_inverse === ~srdo_plain) accepted++;
    // One receive object per call; released data shows the inverse
    task automatic send(input logic [63:0] d);
        @(posedge clk);
        rpdo_valid <= 1'h1;
        rpdo_data <= d;
        @(posedge clk);
        rpdo_valid <= 1'h0;
        rpdo_data <= ~d;
    endtask
endmodule // net_master_model

// ==== testbench/safe_process_value_objects_tb.sv ====
// Self-checking bench for the safe process value objects.
// Assumes design, checker and master model compiled first.
`timescale 1ns/1ns
module safe_process_value_objects_tb;
    logic clk = 1'h0, reset = 1'h1, sample_valid = 1'h0;
    logic obj_req = 1'h0, obj_write = 1'h0;
    logic [7:0] s_st = 8'h00, obj_sub = 8'h00, tpdo_status_r;
    logic [15:0] obj_index = 16'h0000, obj_wdata = 16'h0000;
    logic [15:0] s_v [8] = '{default: 16'h0000};
    logic obj_done_r, obj_abort_r, tpdo_valid_r, srdo_valid_r, srdo_fault_r;
    logic rx_new_r, rpdo_valid, norate_abort, norate_valid;
    logic [15:0] obj_rdata_r, tpdo_tilt_long_r, tpdo_tilt_lat_r;
    safe_pv_pkg::srdo_num_t srdo_num_r;
    logic [47:0] srdo_plain_r, srdo_inverse_r;
    logic [47:0] frm [3];
    logic [63:0] rpdo_data, rx_data_r, last_rx;
    int err_total = 0, cmp_count = 0, cycles = 0, n_smp = 0, n_rx = 0, n_tp = 0, n_norate = 0;
    logic [15:0] cfgs [4] = '{16'h0001, 16'h0003, 16'h0002, 16'h0001};

    safe_process_value_objects safe_process_value_objects_i (.clk, .reset, .sample_valid,
        .sample_status(s_st), .sample_tilt_long(s_v[0]), .sample_tilt_lat(s_v[1]),
        .sample_accel_x(s_v[2]), .sample_accel_y(s_v[3]), .sample_accel_z(s_v[4]),
        .sample_rate_x(s_v[5]), .sample_rate_y(s_v[6]), .sample_rate_z(s_v[7]),
        .obj_req, .obj_write, .obj_index, .obj_sub, .obj_wdata, .obj_done_r, .obj_abort_r,
        .obj_rdata_r, .tpdo_valid_r, .tpdo_status_r, .tpdo_tilt_long_r, .tpdo_tilt_lat_r,
        .srdo_valid_r, .srdo_num_r, .srdo_plain_r, .srdo_inverse_r, .srdo_fault_r,
        .rpdo_valid, .rpdo_data, .rx_new_r, .rx_data_r);
    net_master_model nm_i (.clk, .srdo_valid(srdo_valid_r), .srdo_plain(srdo_plain_r),
        .srdo_inverse(srdo_inverse_r), .rpdo_valid, .rpdo_data);
    // Variant without the rate sensor, on the same stimulus
    if (1) begin : g_norate
        safe_process_value_objects #(.RATE_FITTED(1'b0)) safe_process_value_objects_i (.clk,
            .reset, .sample_valid, .sample_status(s_st), .sample_tilt_long(s_v[0]),
            .sample_tilt_lat(s_v[1]), .sample_accel_x(s_v[2]), .sample_accel_y(s_v[3]),
            .sample_accel_z(s_v[4]), .sample_rate_x(s_v[5]), .sample_rate_y(s_v[6]),
            .sample_rate_z(s_v[7]), .obj_req, .obj_write, .obj_index, .obj_sub, .obj_wdata,
            .obj_done_r(), .obj_abort_r(norate_abort), .obj_rdata_r(), .tpdo_valid_r(),
            .tpdo_status_r(), .tpdo_tilt_long_r(), .tpdo_tilt_lat_r(),
            .srdo_valid_r(norate_valid), .srdo_num_r(), .srdo_plain_r(), .srdo_inverse_r(),
            .srdo_fault_r(), .rpdo_valid, .rpdo_data, .rx_new_r(), .rx_data_r());
    end

    // Clock
    initial forever #4 clk = ~clk;
    // Frame and receive capture, cycle ceiling
    always @(posedge clk) begin
        cycles++;
        if (srdo_valid_r) frm[srdo_num_r] = srdo_plain_r;
        if (rx_new_r) last_rx = rx_data_r;
        if (rx_new_r) n_rx++;
        if (tpdo_valid_r) n_tp++;
        if (norate_valid) n_norate++;
        if (cycles == 20000) begin
            err_total++;
            summarize();
        end
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One object access; answer sampled one cycle after the request
    task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [15:0] wd, input logic [15:0] exp, input logic ab);
        @(posedge clk);
        obj_req <= 1'h1;
        obj_write <= wr;
        obj_index <= idx;
        obj_sub <= sub;
        obj_wdata <= wd;
        @(posedge clk);
        obj_req <= 1'h0;
        @(posedge clk);
        chk(obj_abort_r, ab);
        chk(obj_done_r, !ab);
        chk(norate_abort, ab || (idx[11:0] == 12'h131));
        if (!ab && !wr) chk(obj_rdata_r, exp);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] e);
        acc(1'h0, idx, sub, 16'h0000, e, 1'h0);
    endtask
    // Sample; gap of 1 to 3 offers a second sample while busy
    task automatic smp(input logic [7:0] st, input logic [15:0] b, input int gap);
        frm = '{default: 48'h0};
        @(posedge clk);
        sample_valid <= 1'h1;
        s_st <= st;
        for (int i = 0; i < 8; i++) s_v[i] <= b + 16'(i * 16'h0111);
        @(posedge clk);
        sample_valid <= 1'h0;
        if (gap > 0) begin
            repeat (gap) @(posedge clk);
            sample_valid <= 1'h1;
            s_st <= ~st;
            for (int i = 0; i < 8; i++) s_v[i] <= ~s_v[i];
            @(posedge clk);
            sample_valid <= 1'h0;
        end
        repeat (7) @(posedge clk);
        n_smp++;
    endtask
    // Plain and inverted objects, transmit data and frames of one sample
    task automatic chk_all(input logic [7:0] st, input logic [15:0] b, input logic neg);
        logic [15:0] v [8];
        for (int i = 0; i < 8; i++) v[i] = b + 16'(i * 16'h0111);
        if (neg) v[1] = -v[1];
        rd(16'h5000, 8'h00, {8'h00, st});
        rd(16'h4000, 8'h00, {8'h00, ~st});
        rd(16'h6010, 8'h00, v[0]);
        rd(16'h4010, 8'h00, ~v[0]);
        rd(16'h6020, 8'h00, v[1]);
        rd(16'h4020, 8'h00, ~v[1]);
        for (int i = 0; i < 3; i++) begin
            rd(16'h5130, 8'(i + 1), v[i + 2]);
            rd(16'h4130, 8'(i + 1), ~v[i + 2]);
            rd(16'h5131, 8'(i + 1), v[i + 5]);
            rd(16'h4131, 8'(i + 1), ~v[i + 5]);
        end
        chk({tpdo_status_r, tpdo_tilt_long_r, tpdo_tilt_lat_r}, {st, v[0], v[1]});
        chk(frm[0], {v[1], v[0], 8'h00, st});
        chk(frm[1], {v[4], v[3], v[2]});
        chk(frm[2], {v[7], v[6], v[5]});
        chk(64'(nm_i.accepted), 64'(3 * n_smp));
        chk(64'(n_tp), 64'(n_smp));
        chk(64'(n_norate), 64'(2 * n_smp));
        chk(srdo_fault_r, 1'h0);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'h0;
        rd(16'h4000, 8'h00, 16'h00FF);
        rd(16'h4020, 8'h00, 16'hFFFF);
        rd(16'h4130, 8'h00, 16'h0003);
        rd(16'h4131, 8'h00, 16'h0003);
        rd(16'h6021, 8'h00, 16'h0000);
        $display("test reset values done");
        smp(8'h5A, 16'h1123, 0);
        chk_all(8'h5A, 16'h1123, 1'h0);
        $display("test plain and inverted done");
        acc(1'h1, 16'h6020, 8'h00, 16'h0001, 16'h0000, 1'h1);
        acc(1'h0, 16'h4001, 8'h00, 16'h0000, 16'h0000, 1'h1);
        acc(1'h0, 16'h4130, 8'h04, 16'h0000, 16'h0000, 1'h1);
        for (int k = 0; k < 4; k++) begin
            acc(1'h1, 16'h6021, 8'h00, cfgs[k], 16'h0000, 1'h0);
            rd(16'h6021, 8'h00, cfgs[k]);
            smp(8'hA5, k[0] ? 16'h7EEF : 16'h1123, 0);
            chk_all(8'hA5, k[0] ? 16'h7EEF : 16'h1123, cfgs[k][0]);
        end
        $display("test configuration done");
        smp(8'h3C, 16'h0101, 1);
        chk_all(8'h3C, 16'h0101, 1'h1);
        $display("test busy sample done");
        nm_i.send(64'h0123456789ABCDEF);
        nm_i.send(64'hFEDCBA9876543210);
        repeat (2) @(posedge clk);
        chk(last_rx, 64'hFEDCBA9876543210);
        chk(64'(n_rx), 64'h2);
        $display("test receive done");
        summarize();
    end
endmodule // safe_process_value_objects_tb
